// file: dcpwm_channel.sv
// output level of one pwm channel, compared against the shared counter
// assumes counter and compare value are registers on clk_sys_i
`timescale 1ns/100ps

module dcpwm_channel import dcpwm_pkg::*; #(
  parameter int unsigned CNT_W = 8
) (
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic             run_i,
  input  wire logic [CNT_W-1:0] cnt_i,
  input  wire logic [CNT_W-1:0] cmp_i,
  input  wire logic             rst_level_i,
  output logic                  level_o
);

  localparam logic [CNT_W-1:0] CMP_ONES = {CNT_W{1'b1}};

  typedef struct packed {
    logic level;
  } dcpwm_ch_st_t;

  dcpwm_ch_st_t q, d;

  // ----------------------------------------------------------------
  // level: high below the compare value, low from it to the top; compare 0 holds it high, all ones holds it low
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (srst_i) begin
      d.level = rst_level_i;
    end else if (run_i) begin
      if (cmp_i == '0) begin
        d.level = 1'b1;
      end else if (cmp_i == CMP_ONES) begin
        d.level = 1'b0;
      end else begin
        // low from cnt == cmp up to the top, high again after wrap
        d.level = (cnt_i < cmp_i);
      end
    end
    // idle: level frozen where it was
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i || ce_i) begin
      q <= d;
    end
  end

  assign level_o = q.level;

endmodule

// file: dcpwm_load_model.sv
// load model: external circuit that watches one pulse line
// assumes the line is pulled high by the bench whenever the pin is not driven
`timescale 1ns/100ps

module dcpwm_load_model (
  input  wire logic        clk_sys_i,
  input  wire logic        line_i,
  output logic      [15:0] low_len_o,
  output logic             low_vld_o
);
  logic        prev_q = 1'b1;
  logic [15:0] cnt_q  = 16'h0000;

  initial begin
    low_len_o = 16'h0000;
    low_vld_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // low-run meter
  // ----------------------------------------------------------------
  // counts sampled low cycles; a rise reports the run, so a run that
  // never ends (output stuck low) is never reported, like a real meter
  always @(posedge clk_sys_i) begin
    low_vld_o <= 1'b0;
    if (!line_i) begin
      cnt_q <= cnt_q + 16'h0001;
    end else if (!prev_q) begin
      low_len_o <= cnt_q;
      low_vld_o <= 1'b1;
      cnt_q     <= 16'h0000;
    end
    prev_q <= line_i;
  end
endmodule

// file: dcpwm_pkg.sv
// constants, field positions and enumerations of the dual-channel pwm unit
// assumes an 8-bit register port and one system clock shared by all files

package dcpwm_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CMP0   = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CTRL_A = 4'h2;
  localparam logic [ADDR_W-1:0] REG_CTRL_C = 4'h3;
  localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRLA_RUN_BIT = 7;
  localparam int unsigned CTRLA_CLR_BIT = 6;
  localparam int unsigned CTRLA_OE_LSB  = 0;
  localparam int unsigned CTRLC_SRC_LSB = 0;
  localparam int unsigned CTRLC_PRE_LSB = 2;
  localparam int unsigned STAT_LVL_LSB  = 0;
  localparam int unsigned STAT_RUN_BIT  = 2;
  localparam int unsigned STAT_ICP_BIT  = 3;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // tick source and prescale encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_CPU  = 2'b00,
    SRC_T0   = 2'b01,
    SRC_T1   = 2'b10,
    SRC_NONE = 2'b11
  } dcpwm_src_t;

  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV2 = 2'b01,
    PRE_DIV4 = 2'b10,
    PRE_DIV8 = 2'b11
  } dcpwm_pre_t;

endpackage

// file: dcpwm_prescaler.sv
// tick source selection and prescaler of the pwm counter
// assumes timer overflow inputs are one-cycle pulses on clk_sys_i
`timescale 1ns/100ps

module dcpwm_prescaler import dcpwm_pkg::*; #(
  parameter int unsigned PRE_W = 3
) (
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       run_i,
  input  wire dcpwm_src_t src_i,
  input  wire dcpwm_pre_t pre_i,
  input  wire logic       tmr0_ovf_i,
  input  wire logic       tmr1_ovf_i,
  output logic            tick_o
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (PRE_W < 3) begin : g_chk
    $error("prescaler counter too narrow for divide by 8");
  end

  typedef struct packed {
    logic [PRE_W-1:0] div;
    logic             tick;
  } dcpwm_pre_st_t;

  dcpwm_pre_st_t q, d;

  // last count value before a tick, per prescale setting
  function automatic logic [PRE_W-1:0] div_limit(input dcpwm_pre_t p);
    case (p)
      PRE_DIV1: div_limit = PRE_W'(0);
      PRE_DIV2: div_limit = PRE_W'(1);
      PRE_DIV4: div_limit = PRE_W'(3);
      default:  div_limit = PRE_W'(7);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic pulse;
    pulse = 1'b0;
    d = q;
    d.tick = 1'b0;
    case (src_i)
      SRC_CPU: pulse = 1'b1;
      SRC_T0:  pulse = tmr0_ovf_i;
      SRC_T1:  pulse = tmr1_ovf_i;
      default: pulse = 1'b0;
    endcase
    // a halted unit keeps its partial count so a restart is seamless
    if (run_i && pulse) begin
      if (q.div >= div_limit(pre_i)) begin
        d.div  = '0;
        d.tick = 1'b1;
      end else begin
        d.div = q.div + 1'b1;
      end
    end
    if (srst_i) begin
      d = '0;
    end
  end

  // reset acts even while the clock enable is low
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || ce_i) begin
      q <= d;
    end
  end

  assign tick_o = q.tick;

endmodule

// file: dcpwm_top.sv
// dual-channel pwm unit: registers, shared counter, compare buffers, pin steering
// assumes a same-clock register master and same-clock timer overflow pulses;
// the strap and programming-mode inputs are pins and are synchronised here
`timescale 1ns/100ps

module dcpwm_top import dcpwm_pkg::*; #(
  parameter int unsigned CNT_W  = 8,
  parameter int unsigned NUM_CH = 2
) (
  input  wire logic              clk_sys_i,
  input  wire logic              srst_i,
  input  wire logic              ce_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  output logic      [DATA_W-1:0] rd_data_o,
  input  wire logic              tmr0_ovf_i,
  input  wire logic              tmr1_ovf_i,
  input  wire logic              reset_output_level_cfg_i,
  input  wire logic              serial_programming_mode_i,
  input  wire logic [NUM_CH-1:0] port_data_i,
  input  wire logic [NUM_CH-1:0] port_oe_i,
  output logic      [NUM_CH-1:0] pin_o,
  output logic      [NUM_CH-1:0] pin_oe_o
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (CNT_W < 2 || CNT_W > DATA_W) begin : g_chk_cnt
    $error("counter width must lie between 2 and the data width");
  end
  if (NUM_CH < 1 || NUM_CH > 2) begin : g_chk_ch
    $error("one or two channels are supported");
  end

  localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  typedef struct packed {
    logic [NUM_CH-1:0][CNT_W-1:0] cmp_sw;
    logic [NUM_CH-1:0][CNT_W-1:0] cmp_buf;
    logic [CNT_W-1:0]             cnt;
    logic                         run;
    logic [NUM_CH-1:0]            oe;
    dcpwm_src_t                   src;
    dcpwm_pre_t                   pre;
    logic                         icp_s1;
    logic                         icp_s2;
    logic                         lvl_s1;
    logic                         lvl_s2;
    logic [DATA_W-1:0]            rd_data;
    logic [NUM_CH-1:0]            pin;
    logic [NUM_CH-1:0]            pin_oe;
  } dcpwm_top_st_t;

  dcpwm_top_st_t     q, d;
  logic              tick;
  logic [NUM_CH-1:0] lvl;

  // address match, used by both the write and the read decode
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  function automatic logic [ADDR_W-1:0] cmp_off(input int unsigned ch);
    cmp_off = REG_CMP0 + ADDR_W'(ch);
  endfunction

  // ----------------------------------------------------------------
  // tick source and prescaler
  // ----------------------------------------------------------------
  dcpwm_prescaler #(
    .PRE_W (3)
  ) u_pre (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .ce_i       (ce_i),
    .run_i      (q.run),
    .src_i      (q.src),
    .pre_i      (q.pre),
    .tmr0_ovf_i (tmr0_ovf_i),
    .tmr1_ovf_i (tmr1_ovf_i),
    .tick_o     (tick)
  );

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  for (genvar gi = 0; gi < NUM_CH; gi++) begin : g_ch
    dcpwm_channel #(
      .CNT_W (CNT_W)
    ) u_ch (
      .clk_sys_i   (clk_sys_i),
      .srst_i      (srst_i),
      .ce_i        (ce_i),
      .run_i       (q.run),
      .cnt_i       (q.cnt),
      .cmp_i       (q.cmp_buf[gi]),
      .rst_level_i (q.lvl_s2),
      .level_o     (lvl[gi])
    );
  end

  // ----------------------------------------------------------------
  // next state: register port, counter, buffers, pins
  // ----------------------------------------------------------------
  always_comb begin
    logic clr_wr;
    logic step;
    clr_wr = 1'b0;
    step   = 1'b0;
    d = q;
    // pin synchronisers, first stage read by the second only
    d.icp_s1 = serial_programming_mode_i;
    d.icp_s2 = q.icp_s1;
    d.lvl_s1 = reset_output_level_cfg_i;
    d.lvl_s2 = q.lvl_s1;

    // register writes
    if (wr_en_i) begin
      for (int unsigned i = 0; i < NUM_CH; i++) begin
        if (reg_hit(addr_i, cmp_off(i))) begin
          d.cmp_sw[i] = wr_data_i[CNT_W-1:0];
        end
      end
      if (reg_hit(addr_i, REG_CTRL_A)) begin
        d.run  = wr_data_i[CTRLA_RUN_BIT];
        d.oe   = wr_data_i[CTRLA_OE_LSB +: NUM_CH];
        clr_wr = wr_data_i[CTRLA_CLR_BIT];
      end
      if (reg_hit(addr_i, REG_CTRL_C)) begin
        d.src = dcpwm_src_t'(wr_data_i[CTRLC_SRC_LSB +: 2]);
        d.pre = dcpwm_pre_t'(wr_data_i[CTRLC_PRE_LSB +: 2]);
      end
    end

    // shared counter; a clear wins over a tick in the same cycle
    step = q.run && tick;
    if (clr_wr) begin
      d.cnt = '0;
    end else if (step) begin
      d.cnt = q.cnt + 1'b1;
    end
    // new compare values at every tick from the top count, even when a clear wins that cycle
    if (step && (q.cnt == CNT_MAX)) begin
      d.cmp_buf = q.cmp_sw;
    end

    // register reads; data stand one cycle after the strobe only
    d.rd_data = RST_BYTE;
    if (rd_en_i) begin
      for (int unsigned i = 0; i < NUM_CH; i++) begin
        if (reg_hit(addr_i, cmp_off(i))) begin
          d.rd_data = DATA_W'(q.cmp_sw[i]);
        end
      end
      if (reg_hit(addr_i, REG_CTRL_A)) begin
        d.rd_data[CTRLA_RUN_BIT]             = q.run;
        d.rd_data[CTRLA_OE_LSB +: NUM_CH]    = q.oe;
      end
      if (reg_hit(addr_i, REG_CTRL_C)) begin
        d.rd_data[CTRLC_SRC_LSB +: 2] = q.src;
        d.rd_data[CTRLC_PRE_LSB +: 2] = q.pre;
      end
      if (reg_hit(addr_i, REG_COUNT)) begin
        d.rd_data = DATA_W'(q.cnt);
      end
      if (reg_hit(addr_i, REG_STATUS)) begin
        d.rd_data[STAT_LVL_LSB +: NUM_CH] = lvl;
        d.rd_data[STAT_RUN_BIT]           = q.run;
        d.rd_data[STAT_ICP_BIT]           = q.icp_s2;
      end
    end

    // pin steering: programming mode floats every pulse pin
    for (int unsigned i = 0; i < NUM_CH; i++) begin
      if (q.icp_s2) begin
        d.pin[i]    = 1'b0;
        d.pin_oe[i] = 1'b0;
      end else if (q.oe[i]) begin
        d.pin[i]    = lvl[i];
        d.pin_oe[i] = 1'b1;
      end else begin
        d.pin[i]    = port_data_i[i];
        d.pin_oe[i] = port_oe_i[i];
      end
    end

    // synchronous reset; synchronisers keep sampling meanwhile
    if (srst_i) begin
      d.cmp_sw  = '0;
      d.cmp_buf = '0;
      d.cnt     = '0;
      d.run     = 1'b0;
      d.oe      = '0;
      d.src     = SRC_CPU;
      d.pre     = PRE_DIV1;
      d.rd_data = RST_BYTE;
      d.pin     = '0;
      d.pin_oe  = '0;
    end
  end

  // reset acts even while the clock enable is low
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || ce_i) begin
      q <= d;
    end
  end

  assign rd_data_o = q.rd_data;
  assign pin_o     = q.pin;
  assign pin_oe_o  = q.pin_oe;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  logic clr_now;
  logic wrap_now;
  assign clr_now  = wr_en_i && reg_hit(addr_i, REG_CTRL_A) && wr_data_i[CTRLA_CLR_BIT];
  assign wrap_now = ce_i && q.run && tick && !clr_now && (q.cnt == CNT_MAX);

  a_cnt_wrap: assert property (wrap_now |=> q.cnt == '0)
    else $error("counter did not restart from zero at overflow");

  a_cnt_step: assert property (
    (ce_i && q.run && tick && !clr_now && q.cnt != CNT_MAX)
    |=> q.cnt == $past(q.cnt) + 1'b1)
    else $error("counter did not advance by one on a tick");

  a_src_silent: assert property (
    (ce_i && q.run && q.src == SRC_T0 && !tmr0_ovf_i) |=> !tick)
    else $error("tick without a timer 0 overflow");

  // any source divided by two can never tick in two cycles running
  a_pre_div2: assert property (
    (ce_i && q.run && q.pre == PRE_DIV2 && tick) |=> !tick)
    else $error("divide by two gave back to back ticks");

  a_reset_level: assert property (
    @(posedge clk_sys_i) disable iff (1'b0)
    (srst_i && q.lvl_s2) |=> lvl == '1)
    else $error("channel level not high after reset with strap set");

  a_cmp_low: assert property (
    (ce_i && q.run && q.cmp_buf[0] != '0 && q.cnt >= q.cmp_buf[0])
    |=> !lvl[0])
    else $error("channel not low at or above its compare value");

  a_cmp_high: assert property (
    (ce_i && q.run && q.cmp_buf[0] != CNT_MAX && q.cnt < q.cmp_buf[0])
    |=> lvl[0])
    else $error("channel not high below its compare value");

  a_cmp_zero: assert property (
    (ce_i && q.run && q.cmp_buf[0] == '0) |=> lvl[0])
    else $error("compare zero did not hold the output high");

  a_cmp_ones: assert property (
    (ce_i && q.run && q.cmp_buf[0] == CNT_MAX) |=> !lvl[0])
    else $error("compare all ones did not hold the output low");

  a_buf_load: assert property (wrap_now |=> q.cmp_buf == $past(q.cmp_sw))
    else $error("compare buffers not loaded at overflow");

  a_buf_hold: assert property (!wrap_now |=> $stable(q.cmp_buf))
    else $error("compare buffers changed away from overflow");

  a_run_bit: assert property (
    (ce_i && wr_en_i && reg_hit(addr_i, REG_CTRL_A))
    |=> q.run == $past(wr_data_i[CTRLA_RUN_BIT]))
    else $error("run bit not taken from write data");

  a_clear_cnt: assert property ((ce_i && clr_now) |=> q.cnt == '0)
    else $error("counter clear did not zero the counter");

  a_idle_hold: assert property (
    (ce_i && !q.run && !clr_now) |=> $stable(q.cnt) && $stable(lvl))
    else $error("idle unit changed counter or output level");

  a_icp_float: assert property ((ce_i && q.icp_s2) |=> pin_oe_o == '0)
    else $error("pulse pin driven during programming mode");

  a_oe_route: assert property (
    (ce_i && !q.icp_s2 && q.oe[0]) |=> pin_oe_o[0] && pin_o[0] == $past(lvl[0]))
    else $error("enabled channel pulse did not reach its pin");

  c_overflow: cover property (wrap_now ##1 q.cmp_buf != '0);
  c_low_pulse: cover property (q.run && lvl[0] ##1 !lvl[0] ##[1:300] lvl[0]);
  c_icp_entry: cover property (q.oe[0] && pin_oe_o[0] ##1 !pin_oe_o[0] && q.icp_s2);

endmodule

// file: tb.sv
// self-checking bench of the dual-channel pwm unit with two load models
// assumes timer pulses every 3 and 5 cycles and pulled-up pins outside the unit
`timescale 1ns/100ps

module tb import dcpwm_pkg::*;;
  localparam dcpwm_src_t SRCS [4] = '{SRC_CPU, SRC_T0, SRC_T1, SRC_CPU};
  localparam dcpwm_pre_t PRES [4] = '{PRE_DIV1, PRE_DIV2, PRE_DIV4, PRE_DIV8};
  localparam int         PERS [4] = '{1, 6, 20, 8};
  localparam logic [15:0] ANY     = 16'hFFFF;

  logic              clk_sys_i, srst_i, ce_i, wr_en_i, rd_en_i, tmr0_ovf_i, tmr1_ovf_i;
  logic              strap, spm, vld0, vld1;
  logic              p1 = 1'b0;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wr_data_i, rd_data_o, c0, c1, o0, o1;
  logic [1:0]        port_data_i, port_oe_i, pin_o, pin_oe_o, line;
  logic [15:0]       len0, len1;
  logic [31:0]       seed;
  logic [7:0]        rq [$];
  logic [15:0]       lq0 [$];
  logic [15:0]       lq1 [$];
  int                num_errors, tests_run, per;
  int                phase = 0;

  dcpwm_top #(.CNT_W(8), .NUM_CH(2)) dut_u (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .tmr0_ovf_i(tmr0_ovf_i), .tmr1_ovf_i(tmr1_ovf_i), .reset_output_level_cfg_i(strap),
    .serial_programming_mode_i(spm), .port_data_i(port_data_i), .port_oe_i(port_oe_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o));

  // pull-ups on the pins: an undriven pin reads high
  assign line[0] = pin_oe_o[0] ? pin_o[0] : 1'b1;
  assign line[1] = pin_oe_o[1] ? pin_o[1] : 1'b1;

  dcpwm_load_model load0_u (.clk_sys_i(clk_sys_i), .line_i(line[0]),
                            .low_len_o(len0), .low_vld_o(vld0));
  dcpwm_load_model load1_u (.clk_sys_i(clk_sys_i), .line_i(line[1]),
                            .low_len_o(len1), .low_vld_o(vld1));

  // ----------------------------------------------------------------
  // clock, timer pulses, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  // fixed pulse spacing keeps every low run an exact multiple of cycles
  always @(posedge clk_sys_i) begin
    phase      <= (phase == 14) ? 0 : phase + 1;
    tmr0_ovf_i <= (phase % 3 == 0);
    tmr1_ovf_i <= (phase % 5 == 0);
  end

  initial begin
    // the slowest source setting dominates; about twice the expected run
    repeat (80000) @(posedge clk_sys_i);
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  // low run in clock cycles for the present tick spacing
  function automatic logic [15:0] tlen(input logic [7:0] c);
    return (16'h0100 - {8'h00, c}) * 16'(per);
  endfunction

  function automatic logic [7:0] cc(input int i);
    return (8'(PRES[i]) << CTRLC_PRE_LSB) | (8'(SRCS[i]) << CTRLC_SRC_LSB);
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_en_i   <= 1'b1;
    @(posedge clk_sys_i);
    wr_en_i   <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr_i  <= a;
    rd_en_i <= 1'b1;
    rq.push_back(e);
    @(posedge clk_sys_i);
    rd_en_i <= 1'b0;
  endtask

  task automatic expect2(input logic [15:0] a, input logic [15:0] b);
    lq0.push_back(a);
    lq1.push_back(b);
  endtask

  // compare values stay off 00 and FF so every period shows a low run
  task automatic new_cmps();
    seed = xs(seed);
    c0   = 8'h01 + 8'(seed % 254);
    seed = xs(seed);
    c1   = 8'h01 + 8'(seed % 254);
    wr(REG_CMP0, c0);
    wr(REG_CMP0 + 4'h1, c1);
  endtask

  task automatic drain();
    int n;
    n = 0;
    while ((lq0.size() + lq1.size()) > 0 && n < 30000) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n >= 30000) begin
      num_errors++;
      report_and_stop();
    end
    repeat (10) @(posedge clk_sys_i);
  endtask

  task automatic take(input int ch, input logic [15:0] seen);
    logic [15:0] e;
    e = 16'h0000;
    if (ch == 0 && lq0.size() > 0) e = lq0.pop_front();
    if (ch == 1 && lq1.size() > 0) e = lq1.pop_front();
    if (e !== ANY) check("low_run", seen, e);
  endtask

  // ----------------------------------------------------------------
  // result watcher: read data one cycle after the strobe, load reports
  // ----------------------------------------------------------------
  always @(negedge clk_sys_i) begin
    // p1 holds the strobe of the cycle before, whose data stand now only
    if (p1) check("rd_data", {8'h00, rd_data_o}, {8'h00, rq.pop_front()});
    p1 = rd_en_i;
    if (vld0) take(0, len0);
    if (vld1) take(1, len1);
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    srst_i = 1'b1; ce_i = 1'b1; wr_en_i = 1'b0; rd_en_i = 1'b0; addr_i = '0;
    wr_data_i = '0; strap = 1'b1; spm = 1'b0; port_data_i = 2'b11; port_oe_i = 2'b00;
    num_errors = 0; tests_run = 0;
    seed = 32'h1D6F3E9F;
    per = 1;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(REG_CMP0, 8'h00);
    rd(REG_CTRL_A, 8'h00);
    rd(REG_CTRL_C, 8'h00);
    rd(REG_COUNT, 8'h00);
    rd(REG_STATUS, 8'h03);
    rd(4'hF, 8'h00);
    $display("test reset_values done");
    // compares first, then run and clear, enables last
    new_cmps();
    wr(REG_CTRL_A, 8'hC0);
    wr(REG_CTRL_A, 8'h83);
    rd(REG_CTRL_A, 8'h83);
    expect2(tlen(c0), tlen(c1));
    expect2(tlen(c0), tlen(c1));
    $display("test first_periods done");
    // timer 0, timer 1 and cpu sources at divide by 2, 4 and 8, then a compare change mid-period
    for (int i = 1; i < 4; i++) begin
      drain();
      per = PERS[i];
      wr(REG_CTRL_C, cc(i));
      rd(REG_CTRL_C, cc(i));
      expect2(ANY, ANY);
      drain();
      o0 = c0;
      o1 = c1;
      new_cmps();
      expect2(tlen(o0), tlen(o1));
      expect2(tlen(c0), tlen(c1));
      expect2(tlen(c0), tlen(c1));
      $display("test source_%0d done", i);
    end
    // extreme compare values
    // all ones keeps channel 1 low from here on, so only channel 0 reports
    drain();
    wr(REG_CMP0, 8'h00);
    wr(REG_CMP0 + 4'h1, 8'hFF);
    lq0.push_back(tlen(c0));
    drain();
    repeat (2100) @(posedge clk_sys_i);
    rd(REG_STATUS, 8'h05);
    repeat (300) @(posedge clk_sys_i);
    rd(REG_STATUS, 8'h05);
    $display("test extremes done");
    // halt holds levels, clear works while halted
    wr(REG_CTRL_A, 8'h03);
    rd(REG_STATUS, 8'h01);
    wr(REG_CTRL_A, 8'h43);
    rd(REG_COUNT, 8'h00);
    repeat (100) @(posedge clk_sys_i);
    rd(REG_COUNT, 8'h00);
    rd(REG_STATUS, 8'h01);
    $display("test halt done");
    // enables off: pins follow the ordinary port
    lq1.push_back(ANY);
    wr(REG_CTRL_A, 8'h00);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      // driven bits stay high so the loads see no low run
      port_oe_i   <= seed[1:0];
      port_data_i <= seed[3:2] | seed[1:0];
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check("pin_oe", {14'h0, pin_oe_o}, {14'h0, port_oe_i});
      check("pin", {14'h0, pin_o}, {14'h0, port_data_i});
      @(posedge clk_sys_i);
    end
    port_oe_i   <= 2'b00;
    port_data_i <= 2'b11;
    $display("test port_mux done");
    // programming mode floats both pins
    wr(REG_CTRL_A, 8'h03);
    repeat (3) @(posedge clk_sys_i);
    lq1.push_back(ANY);
    spm <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("pin_oe", {14'h0, pin_oe_o}, 16'h0000);
    rd(REG_STATUS, 8'h09);
    spm <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("pin_oe", {14'h0, pin_oe_o}, 16'h0003);
    check("pin", {14'h0, pin_o}, 16'h0001);
    $display("test programming_mode done");
    repeat (10) @(posedge clk_sys_i);
    report_and_stop();
  end
endmodule
